// file: ieee488_asserts.sv
// Purpose: wire-level checks on the bus joining the two ends
// Assumes: one clock; rst synchronous, active high
// Notes:   a low level means asserted on every line
`timescale 1ns/1ps
module ieee488_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] dio_l,
  input wire logic [7:0] ctl_l,
  input wire logic [7:0] dev_dio_o,
  input wire logic [7:0] dev_dio_oe,
  input wire logic [7:0] dev_ctl_o,
  input wire logic [7:0] dev_ctl_oe,
  input wire logic [7:0] host_dio_o,
  input wire logic [7:0] host_dio_oe,
  input wire logic [7:0] host_ctl_o,
  input wire logic [7:0] host_ctl_oe
);
  localparam int dav  = ieee488_pkg::ctl_dav;
  localparam int nrfd = ieee488_pkg::ctl_nrfd;
  localparam int ndac = ieee488_pkg::ctl_ndac;
  localparam int atn  = ieee488_pkg::ctl_atn;
  localparam int ifc  = ieee488_pkg::ctl_ifc;
  localparam int ren  = ieee488_pkg::ctl_ren;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence dav_on;
    $fell(ctl_l[dav]);
  endsequence
  sequence lsn_busy;
    ##[1:8] !ctl_l[nrfd];
  endsequence
  sequence ifc_held;
    !ctl_l[ifc] [*4];
  endsequence

  AST_DEV_OPEN_DRAIN: assert property (
    dev_dio_o == 8'h00 && dev_ctl_o == 8'h00)
    else $error("device drives a bus line high");
  AST_HOST_OPEN_DRAIN: assert property (
    host_dio_o == 8'h00 && host_ctl_o == 8'h00)
    else $error("controller drives a bus line high");
  AST_DAV_DATA_STABLE: assert property (
    !ctl_l[dav] && $past(!ctl_l[dav]) |-> $stable(dio_l))
    else $error("data changed while DAV asserted");
  AST_DAV_NEEDS_RFD: assert property (dav_on |-> $past(ctl_l[nrfd]))
    else $error("DAV asserted while NRFD asserted");
  AST_DATA_BEFORE_DAV: assert property (dav_on |-> $stable(dio_l))
    else $error("data not placed before DAV");
  AST_DAV_HELD_TO_NDAC: assert property (
    $rose(ctl_l[dav]) |-> $past(ctl_l[ndac]))
    else $error("DAV released before NDAC false");
  AST_DEV_TALKS_ATN_FALSE: assert property (
    $rose(dev_ctl_oe[dav]) |-> ctl_l[atn])
    else $error("device started DAV under ATN");
  AST_CTL_ONLY_LINES: assert property (
    !dev_ctl_oe[ifc] && !dev_ctl_oe[ren] && !dev_ctl_oe[atn])
    else $error("device drives a controller line");
  AST_LISTENER_NOT_READY: assert property (dav_on |-> lsn_busy)
    else $error("NRFD not asserted after byte");
  AST_NDAC_HELD: assert property (dav_on |-> !ctl_l[ndac])
    else $error("NDAC released before byte taken");
  // the acceptor must let go of NDAC as well, not only the talker
  AST_IFC_RELEASES: assert property (
    ifc_held |-> !dev_ctl_oe[dav] && !dev_ctl_oe[ndac]
      && dev_dio_oe == 8'h00)
    else $error("device still on the bus under IFC");
endmodule // ieee488_asserts

// file: ieee488_device.sv
// Purpose: instrument end: talker, listener, addressing, remote state
// Assumes: address strap is stable while rst is high
// Notes:   user side sees raw bytes; CR LF appended after tx_last byte
`timescale 1ns/1ps
module ieee488_device (
  input  wire logic       clk,
  input  wire logic       rst,
  ieee488_if.dev          bus,
  input  wire logic [4:0] my_addr,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_taken,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_end,
  input  wire logic       srq_req,
  output logic            remote,
  output logic            listening,
  output logic            talking,
  output logic            dev_clear
);
  // synchronizer stages
  logic [7:0] dio_s1_q, dio_s2_q, ctl_s1_q, ctl_s2_q;
  logic [4:0] addr_q;

  ieee488_pkg::acc_state_t acc_q, acc_d;
  ieee488_pkg::tlk_state_t tlk_q, tlk_d;
  ieee488_pkg::resp_seq_t  seq_q, seq_d;
  logic [7:0] out_q, out_d;
  logic       last_q, last_d;
  logic       listen_d, talk_d, remote_d;
  logic [7:0] rx_byte_d, dio_oe_d, ctl_oe_d;
  logic       rx_valid_d, rx_end_d, taken_d, clear_d;

  logic       atn, eoi, ifc, ren, dav, nrfd, ndac;
  logic       acc_on, tlk_on, ready;
  logic [7:0] rxb;
  logic [6:0] cmd;

  always_comb begin
    // low level means asserted
    atn  = ~ctl_s2_q[ieee488_pkg::ctl_atn];
    eoi  = ~ctl_s2_q[ieee488_pkg::ctl_eoi];
    ifc  = ~ctl_s2_q[ieee488_pkg::ctl_ifc];
    ren  = ~ctl_s2_q[ieee488_pkg::ctl_ren];
    dav  = ~ctl_s2_q[ieee488_pkg::ctl_dav];
    nrfd = ~ctl_s2_q[ieee488_pkg::ctl_nrfd];
    ndac = ~ctl_s2_q[ieee488_pkg::ctl_ndac];
    rxb  = ieee488_pkg::bus_byte(dio_s2_q);
    cmd  = rxb[6:0];

    listen_d   = listening;
    talk_d     = talking;
    remote_d   = remote;
    rx_byte_d  = rx_byte;
    rx_valid_d = 1'b0;
    rx_end_d   = 1'b0;
    taken_d    = 1'b0;
    clear_d    = 1'b0;
    acc_d      = acc_q;
    tlk_d      = tlk_q;
    seq_d      = seq_q;
    out_d      = out_q;
    last_d     = last_q;

    // commands are always taken; data only when addressed and ready
    acc_on = atn | listening;
    ready  = atn | rx_ready;

    case (acc_q)
      ieee488_pkg::acc_idle: begin
        if (acc_on) begin
          acc_d = ieee488_pkg::acc_ready;
        end
      end
      ieee488_pkg::acc_ready: begin
        if (!acc_on) begin
          acc_d = ieee488_pkg::acc_idle;
        end else if (dav && ready) begin
          acc_d = ieee488_pkg::acc_done;
          if (atn) begin
            case (cmd[6:5])
              ieee488_pkg::grp_listen: begin
                if (cmd == ieee488_pkg::cmd_unlisten) begin
                  listen_d = 1'b0;
                end else if (cmd[4:0] == addr_q) begin
                  listen_d = 1'b1;
                  if (ren) begin
                    remote_d = 1'b1;
                  end
                end
              end
              ieee488_pkg::grp_talk: begin
                // another talk address silences us
                talk_d = (cmd != ieee488_pkg::cmd_untalk)
                  && (cmd[4:0] == addr_q);
              end
              ieee488_pkg::grp_second: begin
                // no action on secondary codes
              end
              default: begin
                if (cmd == ieee488_pkg::cmd_dev_clr
                    || (cmd == ieee488_pkg::cmd_sel_clr && listening)) begin
                  clear_d = 1'b1;
                end
                if (cmd == ieee488_pkg::cmd_go_local && listening) begin
                  remote_d = 1'b0;
                end
              end
            endcase
          end else begin
            rx_byte_d  = rxb;
            rx_valid_d = 1'b1;
            // EOI counts as end only with ATN false
            rx_end_d   = (rxb == ieee488_pkg::char_cr) || eoi;
          end
        end
      end
      ieee488_pkg::acc_done: begin
        if (!dav) begin
          acc_d = acc_on ? ieee488_pkg::acc_ready : ieee488_pkg::acc_idle;
        end
      end
      default: acc_d = ieee488_pkg::acc_idle;
    endcase

    tlk_on = talking & ~atn;
    case (tlk_q)
      ieee488_pkg::tlk_idle: begin
        if (tlk_on) begin
          if (seq_q == ieee488_pkg::seq_cr) begin
            out_d = ieee488_pkg::char_cr;
            tlk_d = ieee488_pkg::tlk_wait;
          end else if (seq_q == ieee488_pkg::seq_lf) begin
            out_d = ieee488_pkg::char_lf;
            tlk_d = ieee488_pkg::tlk_wait;
          end else if (tx_valid) begin
            out_d  = tx_byte;
            last_d = tx_last;
            tlk_d  = ieee488_pkg::tlk_wait;
          end
        end
      end
      ieee488_pkg::tlk_wait: begin
        if (!tlk_on) begin
          tlk_d = ieee488_pkg::tlk_idle;
        end else if (!nrfd) begin
          tlk_d = ieee488_pkg::tlk_place;
        end
      end
      ieee488_pkg::tlk_place: begin
        tlk_d = tlk_on ? ieee488_pkg::tlk_dav : ieee488_pkg::tlk_idle;
      end
      ieee488_pkg::tlk_dav: begin
        if (!tlk_on) begin
          tlk_d = ieee488_pkg::tlk_idle;
        end else if (!ndac) begin
          tlk_d = ieee488_pkg::tlk_idle;
          case (seq_q)
            ieee488_pkg::seq_user: begin
              taken_d = 1'b1;
              seq_d   = last_q ? ieee488_pkg::seq_cr : ieee488_pkg::seq_user;
            end
            ieee488_pkg::seq_cr: seq_d = ieee488_pkg::seq_lf;
            default:             seq_d = ieee488_pkg::seq_user;
          endcase
        end
      end
      default: tlk_d = ieee488_pkg::tlk_idle;
    endcase

    if (!ren) begin
      remote_d = 1'b0;
    end
    if (ifc) begin
      listen_d = 1'b0;
      talk_d   = 1'b0;
      acc_d    = ieee488_pkg::acc_idle;
      tlk_d    = ieee488_pkg::tlk_idle;
      seq_d    = ieee488_pkg::seq_user;
    end

    // drivers only pull low or let go
    dio_oe_d = 8'h00;
    ctl_oe_d = 8'h00;
    if (tlk_d == ieee488_pkg::tlk_place || tlk_d == ieee488_pkg::tlk_dav) begin
      dio_oe_d = out_d;
      ctl_oe_d[ieee488_pkg::ctl_eoi] = (seq_q == ieee488_pkg::seq_lf);
    end
    ctl_oe_d[ieee488_pkg::ctl_dav]  = (tlk_d == ieee488_pkg::tlk_dav);
    ctl_oe_d[ieee488_pkg::ctl_nrfd] = (acc_d == ieee488_pkg::acc_done)
      || (acc_d == ieee488_pkg::acc_ready && !ready);
    ctl_oe_d[ieee488_pkg::ctl_ndac] =
      (acc_d == ieee488_pkg::acc_ready);
    ctl_oe_d[ieee488_pkg::ctl_srq]  = srq_req;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dio_s1_q       <= ieee488_pkg::lines_released;
      dio_s2_q       <= ieee488_pkg::lines_released;
      ctl_s1_q       <= ieee488_pkg::lines_released;
      ctl_s2_q       <= ieee488_pkg::lines_released;
      addr_q         <= my_addr;
      acc_q          <= ieee488_pkg::acc_idle;
      tlk_q          <= ieee488_pkg::tlk_idle;
      seq_q          <= ieee488_pkg::seq_user;
      out_q          <= 8'h00;
      last_q         <= 1'b0;
      listening      <= 1'b0;
      talking        <= 1'b0;
      remote         <= 1'b0;
      rx_byte        <= 8'h00;
      rx_valid       <= 1'b0;
      rx_end         <= 1'b0;
      tx_taken       <= 1'b0;
      dev_clear      <= 1'b0;
      bus.dev_dio_o  <= 8'h00;
      bus.dev_ctl_o  <= 8'h00;
      bus.dev_dio_oe <= 8'h00;
      bus.dev_ctl_oe <= 8'h00;
    end else begin
      dio_s1_q       <= bus.dio_l;
      dio_s2_q       <= dio_s1_q;
      ctl_s1_q       <= bus.ctl_l;
      ctl_s2_q       <= ctl_s1_q;
      acc_q          <= acc_d;
      tlk_q          <= tlk_d;
      seq_q          <= seq_d;
      out_q          <= out_d;
      last_q         <= last_d;
      listening      <= listen_d;
      talking        <= talk_d;
      remote         <= remote_d;
      rx_byte        <= rx_byte_d;
      rx_valid       <= rx_valid_d;
      rx_end         <= rx_end_d;
      tx_taken       <= taken_d;
      dev_clear      <= clear_d;
      bus.dev_dio_o  <= 8'h00;
      bus.dev_ctl_o  <= 8'h00;
      bus.dev_dio_oe <= dio_oe_d;
      bus.dev_ctl_oe <= ctl_oe_d;
    end
  end
endmodule // ieee488_device

// file: ieee488_host.sv
// Purpose: controller end: sends commands or data, listens, drives IFC/REN
// Assumes: bus levels come in synchronous to clk
// Notes:   ATN settles a few cycles before the first handshake check
`timescale 1ns/1ps
module ieee488_host (
  input  wire logic       clk,
  input  wire logic       rst,
  ieee488_if.host         bus,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_atn,
  input  wire logic       cmd_eoi,
  output logic            cmd_done,
  input  wire logic       listen_en,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_eoi,
  input  wire logic       ifc_req,
  input  wire logic       ren_req,
  output logic            srq_seen
);
  ieee488_pkg::host_state_t st_q, st_d;
  logic [7:0] byte_q, byte_d;
  logic       atn_q, atn_d, eoi_q, eoi_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] dio_oe_d, ctl_oe_d, rx_byte_d;
  logic       done_d, rx_valid_d, rx_eoi_d;
  logic       dav, nrfd, ndac;

  always_comb begin
    dav        = ~bus.ctl_l[ieee488_pkg::ctl_dav];
    nrfd       = ~bus.ctl_l[ieee488_pkg::ctl_nrfd];
    ndac       = ~bus.ctl_l[ieee488_pkg::ctl_ndac];
    st_d       = st_q;
    byte_d     = byte_q;
    atn_d      = atn_q;
    eoi_d      = eoi_q;
    cnt_d      = cnt_q;
    done_d     = 1'b0;
    rx_valid_d = 1'b0;
    rx_eoi_d   = rx_eoi;
    rx_byte_d  = rx_byte;
    case (st_q)
      ieee488_pkg::host_idle: begin
        cnt_d = 3'h0;
        if (cmd_valid) begin
          byte_d = cmd_byte;
          atn_d  = cmd_atn;
          eoi_d  = cmd_eoi;
          st_d   = ieee488_pkg::host_wait;
        end else if (listen_en) begin
          st_d = ieee488_pkg::host_lready;
        end
      end
      ieee488_pkg::host_wait: begin
        if (cnt_q != ieee488_pkg::atn_settle_cyc) begin
          cnt_d = cnt_q + 3'h1;
        end else if (!nrfd) begin
          st_d = ieee488_pkg::host_place;
        end
      end
      ieee488_pkg::host_place: st_d = ieee488_pkg::host_dav;
      ieee488_pkg::host_dav: begin
        if (!ndac) begin
          done_d = 1'b1;
          st_d   = ieee488_pkg::host_idle;
        end
      end
      ieee488_pkg::host_lready: begin
        if (dav) begin
          rx_byte_d  = ieee488_pkg::bus_byte(bus.dio_l);
          rx_eoi_d   = ~bus.ctl_l[ieee488_pkg::ctl_eoi];
          rx_valid_d = 1'b1;
          st_d       = ieee488_pkg::host_ldone;
        end else if (!listen_en) begin
          st_d = ieee488_pkg::host_idle;
        end
      end
      ieee488_pkg::host_ldone: begin
        if (!dav) begin
          st_d = ieee488_pkg::host_idle;
        end
      end
      default: st_d = ieee488_pkg::host_idle;
    endcase
    dio_oe_d = 8'h00;
    ctl_oe_d = 8'h00;
    if (st_d == ieee488_pkg::host_place || st_d == ieee488_pkg::host_dav) begin
      dio_oe_d = byte_d;
      ctl_oe_d[ieee488_pkg::ctl_eoi] = eoi_d;
    end
    ctl_oe_d[ieee488_pkg::ctl_dav] = (st_d == ieee488_pkg::host_dav);
    ctl_oe_d[ieee488_pkg::ctl_atn] = atn_d && (st_d == ieee488_pkg::host_wait
      || st_d == ieee488_pkg::host_place
      || st_d == ieee488_pkg::host_dav);
    ctl_oe_d[ieee488_pkg::ctl_ndac] = (st_d == ieee488_pkg::host_lready);
    ctl_oe_d[ieee488_pkg::ctl_nrfd] = (st_d == ieee488_pkg::host_ldone);
    ctl_oe_d[ieee488_pkg::ctl_ifc]  = ifc_req;
    ctl_oe_d[ieee488_pkg::ctl_ren]  = ren_req;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q            <= ieee488_pkg::host_idle;
      byte_q          <= 8'h00;
      atn_q           <= 1'b0;
      eoi_q           <= 1'b0;
      cnt_q           <= 3'h0;
      cmd_done        <= 1'b0;
      rx_byte         <= 8'h00;
      rx_valid        <= 1'b0;
      rx_eoi          <= 1'b0;
      srq_seen        <= 1'b0;
      bus.host_dio_o  <= 8'h00;
      bus.host_ctl_o  <= 8'h00;
      bus.host_dio_oe <= 8'h00;
      bus.host_ctl_oe <= 8'h00;
    end else begin
      st_q            <= st_d;
      byte_q          <= byte_d;
      atn_q           <= atn_d;
      eoi_q           <= eoi_d;
      cnt_q           <= cnt_d;
      cmd_done        <= done_d;
      rx_byte         <= rx_byte_d;
      rx_valid        <= rx_valid_d;
      rx_eoi          <= rx_eoi_d;
      srq_seen        <= ~bus.ctl_l[ieee488_pkg::ctl_srq];
      bus.host_dio_o  <= 8'h00;
      bus.host_ctl_o  <= 8'h00;
      bus.host_dio_oe <= dio_oe_d;
      bus.host_ctl_oe <= ctl_oe_d;
    end
  end
endmodule // ieee488_host

// file: ieee488_if.sv
// Purpose: the shared bus wires between the instrument and the controller
// Assumes: every driver is open drain; out is the pulled level
// Notes:   a wire is low when any party enables a low output
`timescale 1ns/1ps
interface ieee488_if;
  logic [7:0] dio_l;
  logic [7:0] ctl_l;
  logic [7:0] dev_dio_o;
  logic [7:0] dev_dio_oe;
  logic [7:0] dev_ctl_o;
  logic [7:0] dev_ctl_oe;
  logic [7:0] host_dio_o;
  logic [7:0] host_dio_oe;
  logic [7:0] host_ctl_o;
  logic [7:0] host_ctl_oe;

  // wired-OR of asserted (low) drivers
  assign dio_l = ~((dev_dio_oe & ~dev_dio_o) | (host_dio_oe & ~host_dio_o));
  assign ctl_l = ~((dev_ctl_oe & ~dev_ctl_o) | (host_ctl_oe & ~host_ctl_o));

  modport dev (
    input  dio_l,
    input  ctl_l,
    output dev_dio_o,
    output dev_dio_oe,
    output dev_ctl_o,
    output dev_ctl_oe
  );

  modport host (
    input  dio_l,
    input  ctl_l,
    output host_dio_o,
    output host_dio_oe,
    output host_ctl_o,
    output host_ctl_oe
  );
endinterface // ieee488_if

// file: ieee488_pkg.sv
// Purpose: shared constants, types and helpers for the instrument bus ends
// Assumes: one clock; bus levels are sampled, low level = asserted
// Notes:   control line vector bit order is given by the ctl_* positions
package ieee488_pkg;

  localparam int unsigned  ctl_dav   = 0;
  localparam int unsigned  ctl_nrfd  = 1;
  localparam int unsigned  ctl_ndac  = 2;
  localparam int unsigned  ctl_atn   = 3;
  localparam int unsigned  ctl_eoi   = 4;
  localparam int unsigned  ctl_srq   = 5;
  localparam int unsigned  ctl_ifc   = 6;
  localparam int unsigned  ctl_ren   = 7;
  localparam int unsigned  ctl_width = 8;

  localparam logic [7:0] char_cr      = 8'h0d;
  localparam logic [7:0] char_lf      = 8'h0a;
  localparam logic [6:0] cmd_unlisten = 7'h3f;
  localparam logic [6:0] cmd_untalk   = 7'h5f;
  localparam logic [6:0] cmd_go_local = 7'h01;
  localparam logic [6:0] cmd_sel_clr  = 7'h04;
  localparam logic [6:0] cmd_dev_clr  = 7'h14;
  localparam logic [1:0] grp_listen   = 2'h1;
  localparam logic [1:0] grp_talk     = 2'h2;
  localparam logic [1:0] grp_second   = 2'h3;

  localparam logic [7:0] lines_released = 8'hff;
  localparam logic [2:0] atn_settle_cyc = 3'h4;

  typedef enum logic [1:0] {seq_user, seq_cr, seq_lf} resp_seq_t;
  typedef enum logic [1:0] {acc_idle, acc_ready, acc_done} acc_state_t;
  typedef enum logic [1:0] {
    tlk_idle, tlk_wait, tlk_place, tlk_dav
  } tlk_state_t;
  typedef enum logic [2:0] {
    host_idle, host_wait, host_place, host_dav, host_lready, host_ldone
  } host_state_t;

  // inverse logic: a low wire carries a one
  function automatic logic [7:0] bus_byte(input logic [7:0] level);
    return ~level;
  endfunction

endpackage

// file: tb_top.sv
// Purpose: drives both user sides of the bus ends and checks results
// Assumes: device strap address 12; inputs change at the falling edge
// Notes:   monitors queue every received byte for later comparison
`timescale 1ns/1ps
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid, cmd_atn, cmd_eoi, cmd_done;
  logic [7:0] cmd_byte, h_rx_byte, d_rx_byte, tx_byte;
  logic       listen_en, h_rx_valid, h_rx_eoi, ifc_req, ren_req, srq_seen;
  logic       tx_valid, tx_last, tx_taken, rx_ready, d_rx_valid, d_rx_end;
  logic       srq_req, remote, listening, talking, dev_clear, dav_q;
  logic [8:0] dq[$];
  logic [8:0] hq[$];
  logic [7:0] wq[$];
  logic [11:0] rows [8] = '{12'h2cd, 12'h4cf, 12'h6cf, 12'h3fb,
                            12'h5f9, 12'h2cd, 12'h01c, 12'h3f0};
  int         bad_count, check_count, clr_n;

  ieee488_if bus ();
  ieee488_host u_ieee488_host (
    .clk(clk), .rst(rst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_atn(cmd_atn), .cmd_eoi(cmd_eoi),
    .cmd_done(cmd_done), .listen_en(listen_en), .rx_byte(h_rx_byte),
    .rx_valid(h_rx_valid), .rx_eoi(h_rx_eoi), .ifc_req(ifc_req),
    .ren_req(ren_req), .srq_seen(srq_seen)
  );
  ieee488_device u_ieee488_device (
    .clk(clk), .rst(rst), .bus(bus), .my_addr(5'h0c), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_taken(tx_taken),
    .rx_ready(rx_ready), .rx_byte(d_rx_byte), .rx_valid(d_rx_valid),
    .rx_end(d_rx_end), .srq_req(srq_req), .remote(remote),
    .listening(listening), .talking(talking), .dev_clear(dev_clear)
  );
  ieee488_asserts u_ieee488_asserts (
    .clk(clk), .rst(rst), .dio_l(bus.dio_l), .ctl_l(bus.ctl_l),
    .dev_dio_o(bus.dev_dio_o), .dev_dio_oe(bus.dev_dio_oe),
    .dev_ctl_o(bus.dev_ctl_o), .dev_ctl_oe(bus.dev_ctl_oe),
    .host_dio_o(bus.host_dio_o), .host_dio_oe(bus.host_dio_oe),
    .host_ctl_o(bus.host_ctl_o), .host_ctl_oe(bus.host_ctl_oe)
  );

  always #2 clk = ~clk;

  always @(posedge clk) begin
    dav_q <= bus.ctl_l[ieee488_pkg::ctl_dav];
    if (dav_q && !bus.ctl_l[ieee488_pkg::ctl_dav])
      wq.push_back(bus.dio_l);
    if (d_rx_valid)
      dq.push_back({d_rx_end, d_rx_byte});
    if (h_rx_valid)
      hq.push_back({h_rx_eoi, h_rx_byte});
    if (dev_clear)
      clr_n++;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic fail_wait;
    bad_count++;
    $display("[FAIL] t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
    results();
  endtask

  task automatic chk_byte(input logic [8:0] g, input logic [8:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_flag(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    int i;
    @(negedge clk);
    cmd_byte = b;
    cmd_atn = atn;
    cmd_eoi = eoi;
    cmd_valid = 1'b1;
    for (i = 0; i < 200 && cmd_done !== 1'b1; i++)
      @(negedge clk);
    if (i == 200)
      fail_wait();
    cmd_valid = 1'b0;
  endtask

  task automatic dtx(input logic [7:0] b, input logic last);
    int i;
    @(negedge clk);
    tx_byte = b;
    tx_last = last;
    tx_valid = 1'b1;
    for (i = 0; i < 200 && tx_taken !== 1'b1; i++)
      @(negedge clk);
    if (i == 200)
      fail_wait();
    tx_valid = 1'b0;
  endtask

  task automatic exp_q(input bit hs, input logic [8:0] e);
    int i;
    for (i = 0; i < 200 && (hs ? hq.size() : dq.size()) == 0; i++)
      @(negedge clk);
    if (i == 200)
      fail_wait();
    if (hs)
      chk_byte(hq.pop_front(), e);
    else
      chk_byte(dq.pop_front(), e);
  endtask

  initial begin
    {cmd_valid, cmd_atn, cmd_eoi, listen_en, ifc_req, ren_req} = 6'h00;
    {tx_valid, tx_last, srq_req} = 3'h0;
    {cmd_byte, tx_byte} = 16'h0000;
    rx_ready = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk_byte({1'b0, bus.ctl_l}, 9'h0ff);
    chk_byte({1'b0, bus.dio_l}, 9'h0ff);
    $display("test reset done");
    foreach (rows[k]) begin
      ren_req = rows[k][3];
      send(rows[k][11:4], 1'b1, 1'b0);
      chk_flag(listening, rows[k][2]);
      chk_flag(talking, rows[k][1]);
      chk_flag(remote, rows[k][0]);
    end
    $display("test address rows done");
    send(8'h2c, 1'b1, 1'b0);
    dq.delete();
    wq.delete();
    send(8'h41, 1'b0, 1'b0);
    chk_byte({1'b0, wq[0]}, {1'b0, ~8'h41});
    exp_q(1'b0, 9'h041);
    send(ieee488_pkg::char_cr, 1'b0, 1'b0);
    exp_q(1'b0, 9'h10d);
    send(8'h42, 1'b0, 1'b1);
    exp_q(1'b0, 9'h142);
    send(8'h2c, 1'b1, 1'b1);
    chk_flag(dq.size() != 0, 1'b0);
    chk_flag(listening, 1'b1);
    dq.delete();
    $display("test listener done");
    rx_ready = 1'b0;
    fork
      send(8'h44, 1'b0, 1'b0);
      begin
        repeat (30) @(negedge clk);
        chk_flag(dq.size() != 0, 1'b0);
        chk_flag(bus.ctl_l[ieee488_pkg::ctl_nrfd], 1'b0);
        rx_ready = 1'b1;
      end
    join
    exp_q(1'b0, 9'h044);
    send(8'h14, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk_flag(clr_n == 1, 1'b1);
    send(8'h04, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk_flag(clr_n == 2, 1'b1);
    $display("test refusal done");
    send(8'h3f, 1'b1, 1'b0);
    // selected clear is ignored once unaddressed
    send(8'h04, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk_flag(clr_n == 2, 1'b1);
    send(8'h4c, 1'b1, 1'b0);
    listen_en = 1'b1;
    dtx(8'h31, 1'b1);
    exp_q(1'b1, 9'h031);
    exp_q(1'b1, {1'b0, ieee488_pkg::char_cr});
    exp_q(1'b1, {1'b1, ieee488_pkg::char_lf});
    listen_en = 1'b0;
    $display("test talker done");
    srq_req = 1'b1;
    repeat (4) @(negedge clk);
    chk_flag(bus.ctl_l[ieee488_pkg::ctl_srq], 1'b0);
    chk_flag(srq_seen, 1'b1);
    srq_req = 1'b0;
    repeat (4) @(negedge clk);
    chk_flag(srq_seen, 1'b0);
    $display("test service request done");
    ren_req = 1'b1;
    send(8'h2c, 1'b1, 1'b0);
    chk_flag(remote, 1'b1);
    ifc_req = 1'b1;
    repeat (6) @(negedge clk);
    ifc_req = 1'b0;
    repeat (4) @(negedge clk);
    chk_flag(talking, 1'b0);
    chk_flag(listening, 1'b0);
    ren_req = 1'b0;
    repeat (5) @(negedge clk);
    chk_flag(remote, 1'b0);
    $display("test interface clear done");
    results();
  end
endmodule // tb_top
